/* File: tb/eesp_master_model.sv */
// Two-wire bus master model: clock, conditions and byte transfers
module eesp_master_model
(
  // Bus lines
  output logic      o_scl,
  output logic      o_oe,
  input  wire logic i_sda
);
  timeunit 1ns;
  timeprecision 1ns;

  // Bus idle: clock stands high, data released
  initial
  begin
    o_scl = 1'b1;
    o_oe  = 1'b0;
  end

  task automatic sstart();
    o_oe = 1'b0;
    #200 o_scl = 1'b1;
    #200 o_oe = 1'b1;
    #200 o_scl = 1'b0;
    #200;
  endtask

  task automatic sstop();
    o_oe = 1'b1;
    #200 o_scl = 1'b1;
    #200 o_oe = 1'b0;
    #400;
  endtask

  // Data changes only while clock low
  task automatic bit_io(input logic b, output logic r);
    o_oe = ~b;
    #200 o_scl = 1'b1;
    #200 r = i_sda;
    #200 o_scl = 1'b0;
    #200;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule // eesp_master_model

/* File: tb/eesp_slave_bench.sv */
// Self-checking bench of the serial EEPROM slave
module eesp_slave_bench
  import eesp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [2:0] SEL = 3'h5;
  localparam logic [7:0] WR  = {4'ha, SEL, 1'b0};
  localparam logic [7:0] RD  = {4'ha, SEL, 1'b1};

  logic       i_ref_clk;
  logic       i_rst_n;
  logic       scl;
  logic       m_oe;
  logic       dut_oe;
  logic       dut_sda;
  logic       busy;
  logic [2:0] chip_sel;
  logic       wp;
  logic [7:0] got [0:31];
  int         mismatches;
  int         tests_run;
  int         cycles;
  wire        sda = (dut_oe ? dut_sda : 1'b1) & ~m_oe;

  eesp_slave #(.P_WRITE_CYCLES(400)) u_eesp_slave (
    .i_ref_clk      (i_ref_clk),
    .i_rst_n        (i_rst_n),
    .i_scl          (scl),
    .i_sda          (sda),
    .o_sda          (dut_sda),
    .o_sda_oe       (dut_oe),
    .i_chip_sel     (chip_sel),
    .i_write_protect(wp),
    .o_busy         (busy)
  );

  eesp_master_model u_eesp_master_model (
    .o_scl(scl),
    .o_oe (m_oe),
    .i_sda(sda)
  );

  initial
  begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  task automatic wrap_up();
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, cycles, 0);
      wrap_up();
    end
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic send(input logic [7:0] d, input logic e);
    logic a;
    u_eesp_master_model.wbyte(d, a);
    chk({7'h0, a}, {7'h0, e});
  endtask

  task automatic set_ptr(input logic [11:0] a);
    u_eesp_master_model.sstart();
    send(WR, 1'b1);
    send({4'h0, a[11:8]}, 1'b1);
    send(a[7:0], 1'b1);
  endtask

  task automatic rd_seq(input int n);
    u_eesp_master_model.sstart();
    send(RD, 1'b1);
    for (int k = 0; k < n; k++) u_eesp_master_model.rbyte(k < n - 1, got[k]);
    u_eesp_master_model.sstop();
  endtask

  task automatic wait_done();
    int t;
    t = 0;
    while (busy !== 1'b0 && t < 3000)
    begin
      @(posedge i_ref_clk);
      #1 t++;
    end
    if (t >= 3000)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, busy, 1'b0);
    end
  endtask

  task automatic wr1(input logic [11:0] a, input logic [7:0] d);
    set_ptr(a);
    send(d, 1'b1);
    u_eesp_master_model.sstop();
    wait_done();
  endtask

  task automatic t_refuse();
    u_eesp_master_model.sstart();
    send({4'h9, SEL, 1'b0}, 1'b0);
    u_eesp_master_model.sstart();
    send({4'ha, 3'h2, 1'b0}, 1'b0);
    u_eesp_master_model.sstop();
    chip_sel = 3'h2;
    u_eesp_master_model.sstart();
    send({4'ha, 3'h2, 1'b0}, 1'b1);
    u_eesp_master_model.sstop();
    chip_sel = SEL;
  endtask

  task automatic t_page();
    logic [7:0] j;
    set_ptr(12'h7fe);
    for (j = 8'h00; j < 8'h22; j++) send(8'h40 + j, 1'b1);
    u_eesp_master_model.sstop();
    chk({7'h0, busy}, 8'h01);
    u_eesp_master_model.sstart();
    send(WR, 1'b0);
    u_eesp_master_model.sstop();
    wait_done();
    u_eesp_master_model.sstart();
    send(WR, 1'b1);
    u_eesp_master_model.sstop();
    set_ptr(12'h7e0);
    rd_seq(31);
    for (j = 8'h00; j < 8'h1f; j++) chk(got[j[4:0]], 8'h42 + j);
    rd_seq(1);
    chk(got[0], 8'h61);
  endtask

  task automatic t_protect();
    @(posedge i_ref_clk);
    #1 wp = 1'b1;
    set_ptr(12'h7e0);
    send(8'ha5, 1'b1);
    u_eesp_master_model.sstop();
    chk({7'h0, busy}, 8'h00);
    @(posedge i_ref_clk);
    #1 wp = 1'b0;
    set_ptr(12'h7e0);
    rd_seq(1);
    chk(got[0], 8'h42);
  endtask

  task automatic t_wrap();
    wr1(12'h000, 8'h3c);
    wr1(12'hfff, 8'h5a);
    set_ptr(12'hfff);
    rd_seq(2);
    chk(got[0], 8'h5a);
    chk(got[1], 8'h3c);
  endtask

  initial
  begin
    mismatches = 0;
    tests_run  = 0;
    cycles     = 0;
    i_rst_n    = 1'b0;
    chip_sel   = SEL;
    wp         = 1'b0;
    repeat (8) @(posedge i_ref_clk);
    #1 i_rst_n = 1'b1;
    repeat (3) @(posedge i_ref_clk);
    #1;
    t_refuse();
    t_page();
    t_protect();
    t_wrap();
    wrap_up();
  end
endmodule // eesp_slave_bench

/* File: verilog/eesp_pkg.sv */
// Constants and types of the serial EEPROM slave protocol block
package eesp_pkg;

  localparam int unsigned ADDR_W        = 12;
  localparam int unsigned MEM_BYTES     = 4096;
  localparam int unsigned PAGE_BYTES    = 32;
  localparam int unsigned PAGE_IDX_W    = 5;
  localparam int unsigned PAGE_NUM_W    = ADDR_W - PAGE_IDX_W;
  localparam int unsigned CNT_W         = 4;
  localparam int unsigned TMR_W         = 17;

  localparam logic [3:0]            DEV_CODE   = 4'ha;
  localparam logic [CNT_W-1:0]      BIT_LAST   = 4'h7;
  localparam logic [CNT_W-1:0]      ACK_SLOT   = 4'h8;
  localparam logic [CNT_W-1:0]      CNT_ZERO   = 4'h0;
  // Count parked until the start's own clock fall
  localparam logic [CNT_W-1:0]      CNT_PRE    = 4'hf;
  localparam logic [ADDR_W-1:0]     MAX_ADDR   = 12'hfff;
  localparam logic [ADDR_W-1:0]     ADDR_ZERO  = 12'h000;
  localparam logic [PAGE_IDX_W-1:0] IDX_LAST   = 5'h1f;
  localparam logic [PAGE_IDX_W-1:0] IDX_ZERO   = 5'h00;
  localparam logic [7:0]            BYTE_ZERO  = 8'h00;

  // Self-timed write cycle length
  localparam int unsigned WRITE_TIME_MS = 5;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned WRITE_CYCLES  = (WRITE_TIME_MS * 1000000) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_CTRL    = 3'h1,
    ST_ADDR_HI = 3'h2,
    ST_ADDR_LO = 3'h3,
    ST_WDATA   = 3'h4,
    ST_RDATA   = 3'h5,
    ST_HOLD    = 3'h6
  } eesp_state_e;

  // Bus events found on the sampled lines
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } eesp_line_ev_s;

  // Control byte match against the select pins
  function automatic logic eesp_ctrl_match(input logic [7:0] ctrl,
                                           input logic [2:0] sel);
    eesp_ctrl_match = (ctrl[7:4] == DEV_CODE) && (ctrl[3:1] == sel);
  endfunction

endpackage

/* File: verilog/eesp_slave.sv */
// Serial EEPROM slave: bus decoding, page buffer, write cycle, reads
module eesp_slave
  import eesp_pkg::*;
#(
  parameter int unsigned P_WRITE_CYCLES = WRITE_CYCLES
)
(
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  // Two-wire bus
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe,
  // Strap pins
  input  wire logic [2:0] i_chip_sel,
  input  wire logic       i_write_protect,
  // Status
  output logic            o_busy
);

  // Synchronisers
  logic       scl_m;
  logic       scl_s;
  logic       scl_d;
  logic       sda_m;
  logic       sda_s;
  logic       sda_d;
  logic [2:0] cs_m;
  logic [2:0] cs_s;
  logic       wp_m;
  logic       wp_s;

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      cs_m  <= 3'h0;
      cs_s  <= 3'h0;
      wp_m  <= 1'b0;
      wp_s  <= 1'b0;
    end
    else
    begin
      scl_m <= i_scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= i_sda;
      sda_s <= sda_m;
      sda_d <= sda_s;
      cs_m  <= i_chip_sel;
      cs_s  <= cs_m;
      wp_m  <= i_write_protect;
      wp_s  <= wp_m;
    end
  end

  eesp_line_ev_s ev;

  always_comb
  begin
    ev.scl_rise = scl_s && !scl_d;
    ev.scl_fall = !scl_s && scl_d;
    ev.start    = scl_s && scl_d && !sda_s && sda_d;
    ev.stop     = scl_s && scl_d && sda_s && !sda_d;
  end

  // Protocol state
  eesp_state_e            state;
  logic [CNT_W-1:0]       cnt;
  logic [7:0]             rx_shift;
  logic [7:0]             tx_shift;
  logic                   acked;
  logic                   is_read;
  logic                   mack;
  logic [ADDR_W-1:0]      ptr;
  logic [3:0]             addr_hi;
  logic [7:0]             mem [MEM_BYTES];
  logic [7:0]             pbuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0]  pvld;
  logic [PAGE_NUM_W-1:0]  cmt_page;
  logic [PAGE_IDX_W-1:0]  cmt_idx;
  logic                   cmt_done;
  logic [TMR_W-1:0]       tmr;

  logic       rx_state;
  logic       byte_end;
  logic       ack_end;
  logic       give_ack;
  logic       rd_load;
  logic       launch;
  logic [7:0] rd_byte;

  always_comb
  begin
    rx_state = (state == ST_CTRL) || (state == ST_ADDR_HI) ||
               (state == ST_ADDR_LO) || (state == ST_WDATA);
    byte_end = rx_state && ev.scl_fall && (cnt == BIT_LAST);
    ack_end  = ev.scl_fall && (cnt == ACK_SLOT);
    // Busy refuses every byte; control byte also needs a match
    give_ack = !o_busy && ((state != ST_CTRL) || eesp_ctrl_match(rx_shift, cs_s));
    rd_load  = ack_end && (((state == ST_CTRL) && acked && is_read) ||
                           ((state == ST_RDATA) && mack));
    launch   = ev.stop && (state == ST_WDATA) && (|pvld) && !wp_s && !o_busy;
    rd_byte  = mem[ptr];
  end

  // Receive shifter, most significant bit first
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rx_shift <= BYTE_ZERO;
    else if (rx_state && ev.scl_rise && (cnt != ACK_SLOT))
      rx_shift <= {rx_shift[6:0], sda_s};
  end

  // Transmit shifter
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      tx_shift <= BYTE_ZERO;
    else if (rd_load)
      tx_shift <= rd_byte;
    else if ((state == ST_RDATA) && ev.scl_fall && (cnt < BIT_LAST))
      tx_shift <= {tx_shift[6:0], 1'b0};
  end

  // Bit sequencing and data line drive
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state    <= ST_IDLE;
      cnt      <= CNT_ZERO;
      acked    <= 1'b0;
      is_read  <= 1'b0;
      mack     <= 1'b0;
      o_sda_oe <= 1'b0;
    end
    else if (ev.start)
    begin
      state    <= ST_CTRL;
      cnt      <= CNT_PRE;
      o_sda_oe <= 1'b0;
    end
    else if (ev.stop)
    begin
      state    <= ST_IDLE;
      cnt      <= CNT_ZERO;
      o_sda_oe <= 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE, ST_HOLD:
        begin
          o_sda_oe <= 1'b0;
        end
        ST_CTRL, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA:
        begin
          if (byte_end)
          begin
            cnt      <= ACK_SLOT;
            acked    <= give_ack;
            o_sda_oe <= give_ack;
            if (state == ST_CTRL)
              is_read <= rx_shift[0];
          end
          else if (ack_end)
          begin
            cnt <= CNT_ZERO;
            if (!acked)
            begin
              state    <= ST_HOLD;
              o_sda_oe <= 1'b0;
            end
            else if (state == ST_CTRL && is_read)
            begin
              state    <= ST_RDATA;
              o_sda_oe <= !rd_byte[7];
            end
            else
            begin
              o_sda_oe <= 1'b0;
              unique case (state)
                ST_CTRL:    state <= ST_ADDR_HI;
                ST_ADDR_HI: state <= ST_ADDR_LO;
                default:    state <= ST_WDATA;
              endcase
            end
          end
          else if (ev.scl_fall)
            cnt <= cnt + 4'h1;
        end
        ST_RDATA:
        begin
          if (ev.scl_rise && (cnt == ACK_SLOT))
            mack <= !sda_s;
          if (ev.scl_fall)
          begin
            if (cnt == BIT_LAST)
            begin
              cnt      <= ACK_SLOT;
              o_sda_oe <= 1'b0;
            end
            else if (cnt == ACK_SLOT)
            begin
              cnt <= CNT_ZERO;
              if (mack)
                o_sda_oe <= !rd_byte[7];
              else
              begin
                state    <= ST_HOLD;
                o_sda_oe <= 1'b0;
              end
            end
            else
            begin
              cnt      <= cnt + 4'h1;
              o_sda_oe <= !tx_shift[6];
            end
          end
        end
        default:
        begin
          state    <= ST_IDLE;
          o_sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain output level is always low
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_sda <= 1'b0;
    else
      o_sda <= 1'b0;
  end

  // Address pointer
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ptr     <= ADDR_ZERO;
      addr_hi <= 4'h0;
    end
    else if (byte_end && give_ack && (state == ST_ADDR_HI))
      addr_hi <= rx_shift[3:0];
    else if (byte_end && give_ack && (state == ST_ADDR_LO))
      ptr <= {addr_hi, rx_shift};
    else if (byte_end && give_ack && (state == ST_WDATA))
      ptr[PAGE_IDX_W-1:0] <= ptr[PAGE_IDX_W-1:0] + 5'h01;
    else if (rd_load)
      ptr <= ptr + 12'h001;
  end

  // Page buffer, cleared when a new address is set
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      pvld <= '0;
    else if (byte_end && give_ack && (state == ST_ADDR_LO))
      pvld <= '0;
    else if (byte_end && give_ack && (state == ST_WDATA))
      pvld[ptr[PAGE_IDX_W-1:0]] <= 1'b1;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (byte_end && give_ack && (state == ST_WDATA))
      pbuf[ptr[PAGE_IDX_W-1:0]] <= rx_shift;
  end

  // Write cycle timer and page commit
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_busy   <= 1'b0;
      tmr      <= '0;
      cmt_idx  <= IDX_ZERO;
      cmt_done <= 1'b0;
      cmt_page <= '0;
    end
    else if (launch)
    begin
      o_busy   <= 1'b1;
      tmr      <= '0;
      cmt_idx  <= IDX_ZERO;
      cmt_done <= 1'b0;
      cmt_page <= ptr[ADDR_W-1:PAGE_IDX_W];
    end
    else if (o_busy)
    begin
      if (!cmt_done)
      begin
        cmt_idx <= cmt_idx + 5'h01;
        if (cmt_idx == IDX_LAST)
          cmt_done <= 1'b1;
      end
      if (tmr != TMR_W'(P_WRITE_CYCLES - 1))
        tmr <= tmr + 17'h00001;
      else if (cmt_done)
        o_busy <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (o_busy && !cmt_done && pvld[cmt_idx])
      mem[{cmt_page, cmt_idx}] <= pbuf[cmt_idx];
  end

  // Checks
  AST_ACK_MATCH: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (byte_end && state == ST_CTRL && !o_busy && !ev.start && !ev.stop &&
     eesp_ctrl_match(rx_shift, cs_s)) |=> o_sda_oe [*2])
    else $error("matching control byte not acknowledged");

  AST_NACK_MISMATCH: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (byte_end && state == ST_CTRL && !eesp_ctrl_match(rx_shift, cs_s))
      |=> !o_sda_oe && (ev.start || state == ST_CTRL))
    else $error("foreign control byte acknowledged");

  AST_NO_ACK_BUSY: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (byte_end && o_busy) |=> !o_sda_oe)
    else $error("byte acknowledged during write cycle");

  AST_LAUNCH: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (ev.stop && state == ST_WDATA && (|pvld) && !wp_s && !o_busy)
      |=> o_busy && tmr == '0 && state == ST_IDLE)
    else $error("stop after data did not start write cycle");

  AST_WP_BLOCK: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (ev.stop && wp_s && !o_busy) |=> !o_busy)
    else $error("write cycle started while protected");

  AST_PAGE_INC: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (byte_end && give_ack && state == ST_WDATA) |=>
      ptr[ADDR_W-1:PAGE_IDX_W] == $past(ptr[ADDR_W-1:PAGE_IDX_W]) &&
      ptr[PAGE_IDX_W-1:0] == $past(ptr[PAGE_IDX_W-1:0]) + 5'h01)
    else $error("page pointer step wrong");

  AST_SEQ_WRAP: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (rd_load && ptr == MAX_ADDR) |=> ptr == ADDR_ZERO)
    else $error("read pointer did not wrap");

  AST_NACK_RELEASE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (state == ST_RDATA && ack_end && !mack && !ev.start && !ev.stop)
      |=> !o_sda_oe && state == ST_HOLD)
    else $error("data line held after master nack");

  AST_BUSY_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $rose(o_busy) |-> o_busy [*8])
    else $error("write cycle ended too early");

  AST_ABORT: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    ev.start |=> state == ST_CTRL && cnt == CNT_PRE && !o_sda_oe)
    else $error("start did not restart control byte");

endmodule // eesp_slave
